// ==== autoneg_page_exchange_regs.sv ====
// auto-negotiation page exchange registers behind an axi4-lite slave
// Behaviour
// (RULE1) partner ability bits 9..5 reported, reset zero
// (RULE2) partner selector in bits 4..0, reset zero
// (RULE3) parallel detection fault latches high until read
// (RULE4) partner next-page able bit, read-only
// (RULE5) local next-page able reads constant one
// (RULE6) new page received latches high until read
// (RULE7) partner auto-negotiation able bit, read-only
// (RULE8) writable next-page bit, reset zero
// (RULE9) writable message-page bit, reset one
// (RULE10) writable acknowledge-2 bit, reset zero
// (RULE11) toggle reads inverse of last exchanged toggle
// (RULE12) eleven-bit code field sent with page
// (RULE13) code field resets to null message code
// (RULE14) partner next page bits shown read-only
// (RULE15) latched bits clear on read or reset
// (RULE16) reserved bits zero, read-only writes ignored
`timescale 1ns/1ns
`include "an_page_cfg.svh"
module autoneg_page_exchange_regs #(
  parameter int ADDR_W = 8
) (
  // clock and reset
  input  wire logic              aclk,
  input  wire logic              aresetn,
  // axi4-lite write address
  input  wire logic [ADDR_W-1:0] awaddr,
  input  wire logic [2:0]        awprot,
  input  wire logic              awvalid,
  output logic                   awready,
  // axi4-lite write data
  input  wire logic [31:0]       wdata,
  input  wire logic [3:0]        wstrb,
  input  wire logic              wvalid,
  output logic                   wready,
  // axi4-lite write response
  output logic [1:0]             bresp,
  output logic                   bvalid,
  input  wire logic              bready,
  // axi4-lite read address
  input  wire logic [ADDR_W-1:0] araddr,
  input  wire logic [2:0]        arprot,
  input  wire logic              arvalid,
  output logic                   arready,
  // axi4-lite read data
  output logic [31:0]            rdata,
  output logic [1:0]             rresp,
  output logic                   rvalid,
  input  wire logic              rready,
  // pages from the arbitration logic
  input  wire logic              base_page_valid,
  input  wire logic [15:0]       base_page_word,
  input  wire logic              next_page_valid,
  input  wire logic [15:0]       next_page_word,
  input  wire logic              par_det_fault,
  input  wire logic              lp_np_able,
  input  wire logic              lp_an_able,
  // transmitted link code word
  input  wire logic              lcw_sent,
  input  wire logic              lcw_toggle,
  output logic [15:0]            np_tx_word,
  // interrupt
  output logic                   irq
);

  localparam int IW = ADDR_W - 2;

  // bus handshake state
  logic                    awready_r;
  logic                    wready_r;
  logic                    bvalid_r;
  logic [1:0]              bresp_r;
  logic                    arready_r;
  logic                    rvalid_r;
  logic [1:0]              rresp_r;
  logic [31:0]             rdata_r;
  logic                    aw_got_r;
  logic                    w_got_r;
  logic [IW-1:0]           wr_idx_r;
  logic [15:0]             wd_r;
  logic [1:0]              ws_r;
  // register contents
  an_page_pkg::word16_t    lpa_r;
  an_page_pkg::word16_t    nrx_r;
  logic                    fault_r;
  logic                    page_r;
  logic                    lpnp_r;
  logic                    lpan_r;
  logic                    np_r;
  logic                    mp_r;
  logic                    ack2_r;
  logic                    tog_r;
  an_page_pkg::np_code_t   code_r;
  an_page_pkg::irq_vec_t   ist_r;
  an_page_pkg::irq_vec_t   imsk_r;
  an_page_pkg::irq_vec_t   ist_nxt;
  an_page_pkg::word16_t    np_tx_r;
  logic                    irq_r;
  // decode
  logic                    aw_hs;
  logic                    w_hs;
  logic                    ar_hs;
  logic                    wr_do;
  logic [IW-1:0]           rd_idx;
  logic                    rd_exp;
  logic                    page_evt;
  an_page_pkg::word16_t    rd_word;
  logic                    rd_hit;
  logic                    wr_hit;

  // outputs come straight from flops
  assign awready    = awready_r;
  assign wready     = wready_r;
  assign bvalid     = bvalid_r;
  assign bresp      = bresp_r;
  assign arready    = arready_r;
  assign rvalid     = rvalid_r;
  assign rresp      = rresp_r;
  assign rdata      = rdata_r;
  assign np_tx_word = np_tx_r;
  assign irq        = irq_r;

  // handshakes and read side effects
  assign aw_hs    = awvalid & awready_r;
  assign w_hs     = wvalid & wready_r;
  assign ar_hs    = arvalid & arready_r;
  assign wr_do    = aw_got_r & w_got_r & ~bvalid_r;
  assign rd_idx   = araddr[ADDR_W-1:2];
  assign rd_exp   = ar_hs & (rd_idx == IW'(`AN_IDX_EXP));
  assign page_evt = base_page_valid | next_page_valid;

  // write address channel; one write in flight
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready_r <= 1'b0;
      aw_got_r  <= 1'b0;
      wr_idx_r  <= '0;
    end else if (aw_hs) begin
      awready_r <= 1'b0;
      aw_got_r  <= 1'b1;
      wr_idx_r  <= awaddr[ADDR_W-1:2];
    end else if (bvalid_r & bready) begin
      aw_got_r  <= 1'b0;
    end else if (!aw_got_r) begin
      awready_r <= 1'b1;
    end
  end

  // write data channel, independent of the address
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wready_r <= 1'b0;
      w_got_r  <= 1'b0;
      wd_r     <= '0;
      ws_r     <= '0;
    end else if (w_hs) begin
      wready_r <= 1'b0;
      w_got_r  <= 1'b1;
      wd_r     <= wdata[15:0];
      ws_r     <= wstrb[1:0];
    end else if (bvalid_r & bready) begin
      w_got_r  <= 1'b0;
    end else if (!w_got_r) begin
      wready_r <= 1'b1;
    end
  end

  // map check for writes; read-only registers accept and ignore
  always_comb begin
    wr_hit = 1'b0;
    unique case (wr_idx_r)
      IW'(`AN_IDX_LPA), IW'(`AN_IDX_EXP), IW'(`AN_IDX_NTX), IW'(`AN_IDX_NRX),
      IW'(`AN_IDX_IST), IW'(`AN_IDX_IMSK): wr_hit = 1'b1;
      default: wr_hit = 1'b0;
    endcase
  end

  // write response after both halves arrived
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_r <= 1'b0;
      bresp_r  <= `RESP_OKAY;
    end else if (wr_do) begin
      bvalid_r <= 1'b1;
      bresp_r  <= wr_hit ? `RESP_OKAY : `RESP_SLVERR;
    end else if (bready) begin
      bvalid_r <= 1'b0;
    end
  end

  // next page transmit fields, byte lanes honoured
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      np_r   <= `NTX_NP_RST;
      mp_r   <= `NTX_MP_RST; // RULE9
      ack2_r <= `NTX_ACK2_RST;
      code_r <= `NTX_CODE_RST; // RULE13
    end else if (wr_do && wr_idx_r == IW'(`AN_IDX_NTX)) begin
      if (ws_r[1]) begin
        np_r        <= wd_r[`NTX_NP]; // RULE8
        mp_r        <= wd_r[`NTX_MP]; // RULE9
        ack2_r      <= wd_r[`NTX_ACK2]; // RULE10
        code_r[10:8] <= wd_r[10:8]; // RULE12
      end
      if (ws_r[0]) begin
        code_r[7:0] <= wd_r[7:0]; // RULE12
      end
    end
  end

  // toggle follows the last word on the wire, never software
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tog_r <= `NTX_TOG_RST;
    end else if (lcw_sent) begin
      tog_r <= ~lcw_toggle; // RULE11
    end
  end

  // outgoing page word; bit 14 reserved as zero
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      np_tx_r <= 16'h0000;
    end else begin
      np_tx_r <= {np_r, 1'b0, mp_r, ack2_r, tog_r, code_r}; // RULE12
    end
  end

  // partner pages; reserved ability bit kept zero
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      lpa_r <= `LPA_RST; // RULE1
      nrx_r <= `NRX_RST; // RULE14
    end else begin
      if (base_page_valid) begin
        lpa_r <= base_page_word & `LPA_KEEP; // RULE2
      end
      if (next_page_valid) begin
        nrx_r <= next_page_word; // RULE14
      end
    end
  end

  // latched-high flags: a new event beats the read that clears
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      fault_r <= 1'b0;
      page_r  <= 1'b0;
    end else begin
      if (par_det_fault) begin
        fault_r <= 1'b1; // RULE3
      end else if (rd_exp) begin
        fault_r <= 1'b0; // RULE15
      end
      if (page_evt) begin
        page_r <= 1'b1; // RULE6
      end else if (rd_exp) begin
        page_r <= 1'b0; // RULE15
      end
    end
  end

  // partner ability levels, same clock so no synchroniser
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      lpnp_r <= 1'b0;
      lpan_r <= 1'b0;
    end else begin
      lpnp_r <= lp_np_able; // RULE4
      lpan_r <= lp_an_able; // RULE7
    end
  end

  // interrupt status: set wins over write-one-to-clear
  always_comb begin
    ist_nxt = ist_r;
    if (wr_do && wr_idx_r == IW'(`AN_IDX_IST) && ws_r[0]) begin
      ist_nxt = ist_nxt & ~wd_r[1:0];
    end
    ist_nxt[`IST_PAGE]  = ist_nxt[`IST_PAGE] | page_evt;
    ist_nxt[`IST_FAULT] = ist_nxt[`IST_FAULT] | par_det_fault;
  end

  // status, mask and interrupt line
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ist_r  <= '0;
      imsk_r <= `IMSK_RST;
      irq_r  <= 1'b0;
    end else begin
      ist_r <= ist_nxt;
      if (wr_do && wr_idx_r == IW'(`AN_IDX_IMSK) && ws_r[0]) begin
        imsk_r <= wd_r[1:0];
      end
      irq_r <= |(ist_r & imsk_r);
    end
  end

  // read mux; unlisted bits read zero
  always_comb begin
    rd_word = 16'h0000; // RULE16
    rd_hit  = 1'b1;
    unique case (rd_idx)
      IW'(`AN_IDX_LPA): rd_word = lpa_r; // RULE1
      IW'(`AN_IDX_EXP): begin
        rd_word[`EXP_FAULT] = fault_r;
        rd_word[`EXP_LPNP]  = lpnp_r;
        rd_word[`EXP_LOCNP] = 1'b1; // RULE5
        rd_word[`EXP_PAGE]  = page_r;
        rd_word[`EXP_LPAN]  = lpan_r; // RULE7
      end
      IW'(`AN_IDX_NTX): rd_word = {np_r, 1'b0, mp_r, ack2_r, tog_r, code_r};
      IW'(`AN_IDX_NRX): rd_word = nrx_r;
      IW'(`AN_IDX_IST): rd_word[1:0] = ist_r;
      IW'(`AN_IDX_IMSK): rd_word[1:0] = imsk_r;
      default: rd_hit = 1'b0;
    endcase
  end

  // read channel; data one cycle after the address is taken
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_r <= 1'b0;
      rvalid_r  <= 1'b0;
      rresp_r   <= `RESP_OKAY;
      rdata_r   <= 32'h0000_0000;
    end else if (ar_hs) begin
      arready_r <= 1'b0;
      rvalid_r  <= 1'b1;
      rresp_r   <= rd_hit ? `RESP_OKAY : `RESP_SLVERR;
      rdata_r   <= {16'h0000, rd_word};
    end else if (rvalid_r) begin
      if (rready) begin
        rvalid_r <= 1'b0;
      end
    end else begin
      arready_r <= 1'b1;
    end
  end

  // checks share one clock; only the reset check runs through reset
  default clocking cb_chk @(posedge aclk); endclocking
  default disable iff (!aresetn);
  property p_lpa_bits;
    base_page_valid |=> lpa_r[9:5] == $past(base_page_word[9:5]);
  endproperty
  a_lpa_bits: assert property (p_lpa_bits) else $error("ability bits not captured"); // RULE1
  property p_lpa_sel;
    (!base_page_valid && lpa_r[4:0] == 5'h00) |=> lpa_r[4:0] == 5'h00;
  endproperty
  a_lpa_sel: assert property (p_lpa_sel) else $error("selector changed without a page"); // RULE2
  sequence s_fault;
    par_det_fault;
  endsequence
  // set one cycle after the event, still set one cycle later when nobody read
  sequence s_held_until_read;
    fault_r[*2];
  endsequence
  property p_fault;
    (s_fault ##1 !rd_exp) |-> s_held_until_read;
  endproperty
  a_fault: assert property (p_fault) else $error("fault flag not held"); // RULE3
  property p_lpnp;
    lp_np_able ##1 rd_exp |=> rdata_r[`EXP_LPNP];
  endproperty
  a_lpnp: assert property (p_lpnp) else $error("partner next-page bit wrong"); // RULE4
  property p_locnp;
    rd_exp |=> rvalid_r && rdata_r[`EXP_LOCNP] && rdata_r[15:5] == 11'h000;
  endproperty
  a_locnp: assert property (p_locnp) else $error("expansion constant bits wrong"); // RULE5
  property p_page;
    page_evt |=> page_r && ist_r[`IST_PAGE];
  endproperty
  a_page: assert property (p_page) else $error("page flag not set"); // RULE6
  property p_lpan;
    lp_an_able |=> lpan_r;
  endproperty
  a_lpan: assert property (p_lpan) else $error("partner an-able bit stale"); // RULE7
  property p_np_wr;
    (wr_do && wr_idx_r == IW'(`AN_IDX_NTX) && ws_r[1]) |=> ##1 np_tx_word[15] == $past(wd_r[15], 2);
  endproperty
  a_np_wr: assert property (p_np_wr) else $error("next-page bit not sent"); // RULE8
  property p_tog;
    lcw_sent |=> ##1 np_tx_word[`NTX_TOG] != $past(lcw_toggle, 2);
  endproperty
  a_tog: assert property (p_tog) else $error("toggle not inverted"); // RULE11
  property p_code_rst;
    disable iff (1'b0)
    !aresetn |=> code_r == `NTX_CODE_RST && mp_r;
  endproperty
  a_code_rst: assert property (p_code_rst) else $error("null page not loaded at reset"); // RULE13
  property p_clear;
    (rd_exp && !page_evt && !par_det_fault) |=> !page_r && !fault_r;
  endproperty
  a_clear: assert property (p_clear) else $error("latched flags not cleared by read"); // RULE15
endmodule : autoneg_page_exchange_regs

// ==== an_page_cfg.svh ====
// register indices, field positions and reset values of the page exchange registers
`ifndef AN_PAGE_CFG_SVH
`define AN_PAGE_CFG_SVH
// register indices; byte address is four times the index
`define AN_IDX_LPA 6'h05
`define AN_IDX_EXP 6'h06
`define AN_IDX_NTX 6'h07
`define AN_IDX_NRX 6'h08
`define AN_IDX_IST 6'h10
`define AN_IDX_IMSK 6'h11
// expansion status fields
`define EXP_FAULT 4
`define EXP_LPNP 3
`define EXP_LOCNP 2
`define EXP_PAGE 1
`define EXP_LPAN 0
// next page transmit fields
`define NTX_NP 15
`define NTX_MP 13
`define NTX_ACK2 12
`define NTX_TOG 11
// interrupt status bits
`define IST_PAGE 0
`define IST_FAULT 1
// reset values
`define NTX_NP_RST 1'b0
`define NTX_MP_RST 1'b1
`define NTX_ACK2_RST 1'b0
`define NTX_TOG_RST 1'b0
`define NTX_CODE_RST 11'h001
`define LPA_RST 16'h0000
`define NRX_RST 16'h0000
`define IMSK_RST 2'h0
// partner ability bits that are stored; bit 12 is reserved
`define LPA_KEEP 16'hEFFF
// bus responses
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
`endif

// ==== an_page_pkg.sv ====
// shared types of the page exchange register block
package an_page_pkg;
  typedef logic [15:0] word16_t;
  typedef logic [10:0] np_code_t;
  typedef logic [1:0]  irq_vec_t;
endpackage : an_page_pkg

// ==== an_link_partner_model.sv ====
// behavioural model of the remote partner and arbitration side
`timescale 1ns/1ns
module an_link_partner_model (
  // clock
  input  wire logic   aclk,
  // received pages
  output logic        base_page_valid,
  output logic [15:0] base_page_word,
  output logic        next_page_valid,
  output logic [15:0] next_page_word,
  // fault and ability indications
  output logic        par_det_fault,
  output logic        lp_np_able,
  output logic        lp_an_able,
  // exchanged link code word
  output logic        lcw_sent,
  output logic        lcw_toggle
);
  // idle at time zero
  initial begin
    base_page_valid = 1'b0;
    next_page_valid = 1'b0;
    base_page_word  = 16'h0000;
    next_page_word  = 16'h0000;
    par_det_fault   = 1'b0;
    lp_np_able      = 1'b0;
    lp_an_able      = 1'b0;
    lcw_sent        = 1'b0;
    lcw_toggle      = 1'b0;
  end

  // one-cycle page; word inverted afterwards so stale data never looks valid
  task automatic send_page(input logic nxt, input logic [15:0] w);
    @(posedge aclk);
    base_page_valid <= !nxt;
    next_page_valid <= nxt;
    base_page_word  <= w;
    next_page_word  <= w;
    @(posedge aclk);
    base_page_valid <= 1'b0;
    next_page_valid <= 1'b0;
    base_page_word  <= ~w;
    next_page_word  <= ~w;
  endtask : send_page

  // single-cycle parallel detection fault
  task automatic pulse_fault();
    @(posedge aclk);
    par_det_fault <= 1'b1;
    @(posedge aclk);
    par_det_fault <= 1'b0;
  endtask : pulse_fault

  // partner abilities are levels
  task automatic set_able(input logic np, input logic an);
    @(posedge aclk);
    lp_np_able <= np;
    lp_an_able <= an;
  endtask : set_able

  // word on the wire with its toggle, toggle line inverted after
  task automatic exchange(input logic t);
    @(posedge aclk);
    lcw_sent   <= 1'b1;
    lcw_toggle <= t;
    @(posedge aclk);
    lcw_sent   <= 1'b0;
    lcw_toggle <= ~t;
  endtask : exchange
endmodule : an_link_partner_model

// ==== autoneg_page_exchange_regs_tb_top.sv ====
// self-checking bench for the page exchange register block
`timescale 1ns/1ns
`include "an_page_cfg.svh"
module autoneg_page_exchange_regs_tb_top;
  localparam logic [7:0] A_LPA  = {`AN_IDX_LPA, 2'b00};
  localparam logic [7:0] A_EXP  = {`AN_IDX_EXP, 2'b00};
  localparam logic [7:0] A_NTX  = {`AN_IDX_NTX, 2'b00};
  localparam logic [7:0] A_NRX  = {`AN_IDX_NRX, 2'b00};
  localparam logic [7:0] A_IST  = {`AN_IDX_IST, 2'b00};
  localparam logic [7:0] A_IMSK = {`AN_IDX_IMSK, 2'b00};
  localparam logic [7:0] A_BAD  = 8'h3C;
  logic        aclk, aresetn, awvalid, wvalid, arvalid, bready, rready;
  logic        awready, wready, bvalid, arready, rvalid, irq, lcw_sent, lcw_toggle;
  logic        base_page_valid, next_page_valid, par_det_fault, lp_np_able, lp_an_able;
  logic [15:0] base_page_word, next_page_word, np_tx_word;
  logic [7:0]  awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [3:0]  wstrb;
  logic [2:0]  awprot, arprot;
  logic [1:0]  bresp, rresp;
  int          miscompares, n_checks, cycles;

  autoneg_page_exchange_regs #(.ADDR_W(8)) autoneg_page_exchange_regs_inst (
    .aclk, .aresetn, .awaddr, .awprot, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready,
    .bresp, .bvalid, .bready, .araddr, .arprot, .arvalid, .arready, .rdata, .rresp, .rvalid,
    .rready, .base_page_valid, .base_page_word, .next_page_valid, .next_page_word,
    .par_det_fault, .lp_np_able, .lp_an_able, .lcw_sent, .lcw_toggle, .np_tx_word, .irq);

  an_link_partner_model an_link_partner_model_inst (
    .aclk, .base_page_valid, .base_page_word, .next_page_valid, .next_page_word,
    .par_det_fault, .lp_np_able, .lp_an_able, .lcw_sent, .lcw_toggle);

  // 50 MHz clock
  always #10 aclk = ~aclk;

  // hang guard, far above the few hundred cycles the run needs
  always @(posedge aclk) begin
    cycles++;
    if (cycles == 5000) begin
      miscompares++;
      report_and_stop();
    end
  end

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : report_and_stop

  task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk_word

  task automatic chk_resp(input logic [1:0] got, input logic [1:0] exp);
    chk_word({30'h00000000, got}, {30'h00000000, exp});
  endtask : chk_resp

  task automatic chk_flag(input logic got, input logic exp);
    chk_word({31'h00000000, got}, {31'h00000000, exp});
  endtask : chk_flag

  // address and data offered together, each released when taken
  task automatic axi_wr(input logic [7:0] a, input logic [15:0] v, input logic [3:0] s, output logic [1:0] r);
    logic ap;
    logic wp;
    ap = 1'b1;
    wp = 1'b1;
    awaddr  <= a;
    wdata   <= {16'h0000, v};
    wstrb   <= s;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    while (ap || wp) begin
      @(posedge aclk);
      if (ap && awready) begin
        ap = 1'b0;
        awvalid <= 1'b0;
      end
      if (wp && wready) begin
        wp = 1'b0;
        wvalid <= 1'b0;
      end
    end
    do @(posedge aclk); while (bvalid !== 1'b1);
    r = bresp;
  endtask : axi_wr

  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    araddr  <= a;
    arvalid <= 1'b1;
    do @(posedge aclk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge aclk); while (rvalid !== 1'b1);
    d = rdata;
    r = rresp;
  endtask : axi_rd

  task automatic rd(input logic [7:0] a, input logic [15:0] e);
    logic [31:0] d;
    logic [1:0]  r;
    axi_rd(a, d, r);
    chk_word(d, {16'h0000, e});
    chk_resp(r, `RESP_OKAY);
  endtask : rd

  task automatic wr(input logic [7:0] a, input logic [15:0] v, input logic [3:0] s);
    logic [1:0] r;
    axi_wr(a, v, s, r);
    chk_resp(r, `RESP_OKAY);
  endtask : wr

  // registered outputs lag by a cycle or two
  task automatic settle();
    repeat (2) @(posedge aclk);
    #1;
  endtask : settle

  task automatic t_reset();
    chk_word({16'h0000, np_tx_word}, 32'h00002001);
    rd(A_LPA, 16'h0000);
    rd(A_EXP, 16'h0004);
    rd(A_NTX, 16'h2001);
    rd(A_NRX, 16'h0000);
    chk_flag(irq, 1'b0);
  endtask : t_reset

  task automatic t_unmapped();
    logic [31:0] d;
    logic [1:0]  r;
    axi_rd(A_BAD, d, r);
    chk_word(d, 32'h00000000);
    chk_resp(r, `RESP_SLVERR);
    axi_wr(A_BAD, 16'hFFFF, 4'hF, r);
    chk_resp(r, `RESP_SLVERR);
  endtask : t_unmapped

  task automatic t_ability();
    an_link_partner_model_inst.send_page(1'b0, 16'hFFFF);
    rd(A_LPA, 16'hEFFF);
    an_link_partner_model_inst.send_page(1'b0, 16'h03E1);
    rd(A_LPA, 16'h03E1);
    wr(A_LPA, 16'h0000, 4'hF);
    rd(A_LPA, 16'h03E1);
  endtask : t_ability

  task automatic t_expansion();
    rd(A_EXP, 16'h0006);
    rd(A_EXP, 16'h0004);
    an_link_partner_model_inst.pulse_fault();
    rd(A_EXP, 16'h0014);
    rd(A_EXP, 16'h0004);
    an_link_partner_model_inst.set_able(1'b1, 1'b1);
    wr(A_EXP, 16'hFFFF, 4'hF);
    rd(A_EXP, 16'h000D);
    an_link_partner_model_inst.send_page(1'b1, 16'hA955);
    rd(A_NRX, 16'hA955);
    rd(A_EXP, 16'h000F);
    an_link_partner_model_inst.set_able(1'b0, 1'b0);
    settle();
    rd(A_EXP, 16'h0004);
  endtask : t_expansion

  task automatic t_ntx();
    wr(A_NTX, 16'hFFFF, 4'hF);
    rd(A_NTX, 16'hB7FF);
    settle();
    chk_word({16'h0000, np_tx_word}, 32'h0000B7FF);
    wr(A_NTX, 16'h0000, 4'hF);
    rd(A_NTX, 16'h0000);
    an_link_partner_model_inst.exchange(1'b0);
    rd(A_NTX, 16'h0800);
    an_link_partner_model_inst.exchange(1'b1);
    rd(A_NTX, 16'h0000);
    wr(A_NTX, 16'hFFFF, 4'h1);
    rd(A_NTX, 16'h00FF);
    settle();
    chk_word({16'h0000, np_tx_word}, 32'h000000FF);
  endtask : t_ntx

  // sticky status, mask and level interrupt
  task automatic t_irq();
    wr(A_IST, 16'h0003, 4'hF);
    rd(A_IST, 16'h0000);
    wr(A_IMSK, 16'h0003, 4'hF);
    rd(A_IMSK, 16'h0003);
    an_link_partner_model_inst.pulse_fault();
    settle();
    chk_flag(irq, 1'b1);
    rd(A_IST, 16'h0002);
    wr(A_IMSK, 16'h0001, 4'hF);
    settle();
    chk_flag(irq, 1'b0);
    wr(A_IST, 16'h0002, 4'hF);
    an_link_partner_model_inst.send_page(1'b0, 16'h0021);
    settle();
    chk_flag(irq, 1'b1);
    rd(A_IST, 16'h0001);
    wr(A_IST, 16'h0001, 4'hF);
    settle();
    chk_flag(irq, 1'b0);
  endtask : t_irq

  // reset in mid-run drops latched flags, pages and written fields
  task automatic t_reset_mid();
    an_link_partner_model_inst.pulse_fault();
    an_link_partner_model_inst.send_page(1'b1, 16'hA955);
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    settle();
    chk_word({16'h0000, np_tx_word}, 32'h00002001);
    rd(A_EXP, 16'h0004);
    rd(A_NRX, 16'h0000);
    rd(A_LPA, 16'h0000);
    rd(A_NTX, 16'h2001);
    chk_flag(irq, 1'b0);
  endtask : t_reset_mid

  // reset, then every scenario in turn
  initial begin
    aclk        = 1'b0;
    aresetn     = 1'b0;
    awvalid     = 1'b0;
    wvalid      = 1'b0;
    arvalid     = 1'b0;
    bready      = 1'b1;
    rready      = 1'b1;
    awaddr      = 8'h00;
    araddr      = 8'h00;
    wdata       = 32'h00000000;
    wstrb       = 4'h0;
    awprot      = 3'h0;
    arprot      = 3'h0;
    miscompares = 0;
    n_checks    = 0;
    cycles      = 0;
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    settle();
    t_reset();
    t_unmapped();
    t_ability();
    t_expansion();
    t_ntx();
    t_irq();
    t_reset_mid();
    report_and_stop();
  end
endmodule : autoneg_page_exchange_regs_tb_top
